// ### rtl/cic_pkg.sv
// Purpose: Shared constants and types of the core interrupt control block
// Assumes: Eight-bit core, one register port with byte-wide data
// Notes:   Offsets are word indices on the plain register port
package cic_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_IRQ_CONTROL   = 8'h0b;
    localparam logic [7:0] OFF_OPTION        = 8'h95;
    localparam logic [7:0] OFF_PERIPH_EN_A   = 8'h91;
    localparam logic [7:0] OFF_PERIPH_EN_B   = 8'h92;
    localparam logic [7:0] OFF_PERIPH_REQ_A  = 8'h11;
    localparam logic [7:0] OFF_PERIPH_REQ_B  = 8'h12;
    localparam logic [7:0] OFF_SHADOW_BASE   = 8'he4;
    localparam logic [7:0] OFF_SHADOW_LAST   = 8'heb;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_GLOBAL_EN  = 7;
    localparam int BIT_GROUP_EN   = 6;
    localparam int BIT_TMR_EN     = 5;
    localparam int BIT_PIN_EN     = 4;
    localparam int BIT_IOC_EN     = 3;
    localparam int BIT_TMR_FLAG   = 2;
    localparam int BIT_PIN_FLAG   = 1;
    localparam int BIT_IOC_FLAG   = 0;
    localparam int BIT_EDGE_SEL   = 6;
    localparam int BIT_TIMEOUT    = 4;
    localparam int BIT_POWERDOWN  = 3;

    // ------------------------------------------------------------
    // Reset values, masks and vector
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_IRQ_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_OPTION       = 8'hff;
    localparam logic [7:0]  RST_PERIPH       = 8'h00;
    localparam logic [7:0]  MASK_PERIPH_A    = 8'h48;
    localparam logic [7:0]  MASK_PERIPH_B    = 8'h08;
    localparam logic [7:0]  MASK_STATUS_SAVE = 8'h07;
    localparam logic [14:0] IRQ_VECTOR       = 15'h0004;
    localparam logic [1:0]  Q_PHASES         = 2'h3;
    localparam int          SHADOW_WORDS     = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wreg;
        logic [7:0] status;
        logic [7:0] bank_select_reg;
        logic [7:0] pc_high_latch;
        logic [7:0] fsr0l;
        logic [7:0] fsr0h;
        logic [7:0] fsr1l;
        logic [7:0] fsr1h;
    } cic_ctx_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cic_bus_t;

    typedef enum logic [1:0] {
        SEQ_RUN    = 2'b00,
        SEQ_FLUSH  = 2'b01,
        SEQ_VECTOR = 2'b10,
        SEQ_WAKE   = 2'b11
    } cic_seq_t;

endpackage

// ### rtl/cic_pin_sync.sv
// Purpose: Three-stage synchroniser and edge detector for the external pin
// Assumes: Pin is asynchronous to clock
// Notes:   Edge counts once stages two and three agree
`timescale 1ns/10ps
module cic_pin_sync
    import cic_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Pin and edge choice
    input  wire logic pin_in,
    input  wire logic rising_sel,
    // Result
    output logic      edge_seen
);

    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       level_q;
    logic       level_d;
    logic       edge_d;
    logic       edge_q;

    always_comb
    begin
        sync_d  = {sync_q[1:0], pin_in};
        level_d = level_q;
        edge_d  = 1'b0;
        if (sync_q[1] == sync_q[2])
        begin
            level_d = sync_q[2];
            if (sync_q[2] != level_q)
            begin
                edge_d = rising_sel ? sync_q[2] : ~sync_q[2];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            edge_q  <= 1'b0;
        end
        else
        begin
            sync_q  <= sync_d;
            level_q <= level_d;
            edge_q  <= edge_d;
        end
    end

    assign edge_seen = edge_q;

endmodule

// ### rtl/cic_shadow.sv
// Purpose: Shadow copies of the core context, saved on entry, restored on return
// Assumes: Software reaches the copies through the register port
// Notes:   A save overrides a software write in the same cycle
`timescale 1ns/10ps
module cic_shadow
    import cic_pkg::*;
#(
    parameter int WORDS = SHADOW_WORDS
)
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Save from the core
    input  wire logic       save,
    input  wire cic_ctx_t   live_ctx,
    // Software access
    input  wire logic       sw_wr,
    input  wire logic [2:0] sw_idx,
    input  wire logic [7:0] sw_wdata,
    // Stored copy
    output cic_ctx_t        shadow_ctx
);

    if (WORDS != SHADOW_WORDS)
    begin
        $error("cic_shadow holds exactly eight words");
    end

    logic [7:0] mem_q [WORDS];
    logic [7:0] mem_d [WORDS];

    always_comb
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            mem_d[i] = mem_q[i];
        end
        if (sw_wr)
        begin
            mem_d[sw_idx] = sw_wdata;
        end
        if (save)
        begin
            mem_d[0] = live_ctx.wreg;
            mem_d[1] = (live_ctx.status & MASK_STATUS_SAVE) | (mem_q[1] & ~MASK_STATUS_SAVE);
            mem_d[2] = live_ctx.bank_select_reg;
            mem_d[3] = live_ctx.pc_high_latch;
            mem_d[4] = live_ctx.fsr0l;
            mem_d[5] = live_ctx.fsr0h;
            mem_d[6] = live_ctx.fsr1l;
            mem_d[7] = live_ctx.fsr1h;
        end
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            if (srst)
            begin
                mem_q[i] <= 8'h00;
            end
            else
            begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    assign shadow_ctx = {mem_q[0], mem_q[1] & MASK_STATUS_SAVE, mem_q[2], mem_q[3],
                         mem_q[4], mem_q[5], mem_q[6], mem_q[7]};

endmodule

// ### rtl/cic_core_irq.sv
// Purpose: Interrupt control of a small eight-bit core
// Assumes: Q phases advance on clock; the core obeys flush, push and vector outputs
// Notes:   Peripheral sources pulse their event lines for one clock
`timescale 1ns/10ps
module cic_core_irq
    import cic_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // Event sources
    input  wire logic        ext_pin,
    input  wire logic        tmr_event,
    input  wire logic        ioc_pending,
    input  wire logic [7:0]  periph_event_a,
    input  wire logic [7:0]  periph_event_b,
    // Core sequencer
    input  wire logic        instr_return_from_irq_instr,
    input  wire logic        core_sleeping,
    input  wire cic_ctx_t    live_ctx,
    output logic             irq_request,
    output logic             wake_up,
    output logic             flush_prefetch,
    output logic             push_pc,
    output logic             load_vector,
    output logic [14:0]      vector_addr,
    output logic             restore_ctx,
    output cic_ctx_t         restore_data,
    output logic [1:0]       q_phase
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] opt_q;
    logic [7:0] opt_d;
    logic [7:0] pen_a_q;
    logic [7:0] pen_a_d;
    logic [7:0] pen_b_q;
    logic [7:0] pen_b_d;
    logic [7:0] preq_a_q;
    logic [7:0] preq_a_d;
    logic [7:0] preq_b_q;
    logic [7:0] preq_b_d;
    logic [1:0] q_q;
    logic [1:0] q_d;
    cic_seq_t   seq_q;
    cic_seq_t   seq_d;
    logic       pin_flag_q1_q;
    logic       pin_flag_q1_d;
    logic       pend_q;
    logic       pend_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       pin_edge;
    logic       cycle_end;
    logic       sh_wr;
    logic       take;
    cic_ctx_t   shadow_ctx;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] clear_then_set(input logic [7:0] cur, input logic we,
                                                  input logic [7:0] wd, input logic [7:0] ev,
                                                  input logic [7:0] mask);
        logic [7:0] v;
        v = we ? wd : cur;
        v = (v | ev) & mask;
        return v;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // External pin
    // ------------------------------------------------------------
    cic_pin_sync u_pin
    (
        .clock      (clock),
        .srst       (srst),
        .pin_in     (ext_pin),
        .rising_sel (opt_q[BIT_EDGE_SEL]),
        .edge_seen  (pin_edge)
    );

    // ------------------------------------------------------------
    // Shadow copies
    // ------------------------------------------------------------
    assign sh_wr = reg_wr && (reg_addr >= OFF_SHADOW_BASE) && (reg_addr <= OFF_SHADOW_LAST);

    cic_shadow #(.WORDS(SHADOW_WORDS)) u_shadow
    (
        .clock      (clock),
        .srst       (srst),
        .save       (take),
        .live_ctx   (live_ctx),
        .sw_wr      (sh_wr),
        .sw_idx     (reg_addr[2:0] - OFF_SHADOW_BASE[2:0]),
        .sw_wdata   (reg_wdata),
        .shadow_ctx (shadow_ctx)
    );

    // ------------------------------------------------------------
    // Request evaluation
    // ------------------------------------------------------------
    always_comb
    begin
        cycle_end = (q_q == Q_PHASES);
        pend_d = ((ctl_q[BIT_TMR_EN] & ctl_q[BIT_TMR_FLAG])
               | (ctl_q[BIT_PIN_EN] & pin_flag_q1_q & ctl_q[BIT_PIN_FLAG])
               | (ctl_q[BIT_IOC_EN] & ctl_q[BIT_IOC_FLAG])
               | (ctl_q[BIT_GROUP_EN] & (|(pen_a_q & preq_a_q) | |(pen_b_q & preq_b_q))));
        pin_flag_q1_d = (q_q == 2'h0) ? ctl_q[BIT_PIN_FLAG] : pin_flag_q1_q;
        take = cycle_end && (seq_q == SEQ_RUN) && !core_sleeping && pend_q && ctl_q[BIT_GLOBAL_EN];
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        q_d            = q_q + 2'h1;
        seq_d          = seq_q;
        flush_prefetch = 1'b0;
        push_pc        = 1'b0;
        load_vector    = 1'b0;
        wake_up        = core_sleeping && pend_q;
        case (seq_q)
            SEQ_RUN:
            begin
                if (wake_up)
                begin
                    seq_d = SEQ_WAKE;
                end
                else if (take)
                begin
                    flush_prefetch = 1'b1;
                    seq_d          = SEQ_FLUSH;
                end
            end
            SEQ_WAKE:
            begin
                if (cycle_end)
                begin
                    seq_d = SEQ_RUN;
                end
            end
            SEQ_FLUSH:
            begin
                if (cycle_end)
                begin
                    push_pc = 1'b1;
                    seq_d   = SEQ_VECTOR;
                end
            end
            SEQ_VECTOR:
            begin
                if (cycle_end)
                begin
                    load_vector = 1'b1;
                    seq_d       = SEQ_RUN;
                end
            end
            default:
            begin
                seq_d = SEQ_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers and software access
    // ------------------------------------------------------------
    always_comb
    begin
        ctl_d = ctl_q;
        if (reg_wr && hit(reg_addr, OFF_IRQ_CONTROL))
        begin
            ctl_d = {reg_wdata[7:1], ctl_q[BIT_IOC_FLAG]};
        end
        if (instr_return_from_irq_instr)
        begin
            ctl_d[BIT_GLOBAL_EN] = 1'b1;
        end
        if (take)
        begin
            ctl_d[BIT_GLOBAL_EN] = 1'b0;
        end
        ctl_d[BIT_TMR_FLAG] = ctl_d[BIT_TMR_FLAG] | tmr_event;
        ctl_d[BIT_PIN_FLAG] = ctl_d[BIT_PIN_FLAG] | pin_edge;
        ctl_d[BIT_IOC_FLAG] = ioc_pending;
        opt_d    = (reg_wr && hit(reg_addr, OFF_OPTION)) ? reg_wdata : opt_q;
        pen_a_d  = (reg_wr && hit(reg_addr, OFF_PERIPH_EN_A)) ? (reg_wdata & MASK_PERIPH_A) : pen_a_q;
        pen_b_d  = (reg_wr && hit(reg_addr, OFF_PERIPH_EN_B)) ? (reg_wdata & MASK_PERIPH_B) : pen_b_q;
        preq_a_d = clear_then_set(preq_a_q, reg_wr && hit(reg_addr, OFF_PERIPH_REQ_A), reg_wdata,
                                  periph_event_a, MASK_PERIPH_A);
        preq_b_d = clear_then_set(preq_b_q, reg_wr && hit(reg_addr, OFF_PERIPH_REQ_B), reg_wdata,
                                  periph_event_b, MASK_PERIPH_B);
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_IRQ_CONTROL:  rdata_d = ctl_q;
                OFF_OPTION:       rdata_d = opt_q;
                OFF_PERIPH_EN_A:  rdata_d = pen_a_q;
                OFF_PERIPH_EN_B:  rdata_d = pen_b_q;
                OFF_PERIPH_REQ_A: rdata_d = preq_a_q;
                OFF_PERIPH_REQ_B: rdata_d = preq_b_q;
                8'he4:            rdata_d = shadow_ctx.wreg;
                8'he5:            rdata_d = shadow_ctx.status;
                8'he6:            rdata_d = shadow_ctx.bank_select_reg;
                8'he7:            rdata_d = shadow_ctx.pc_high_latch;
                8'he8:            rdata_d = shadow_ctx.fsr0l;
                8'he9:            rdata_d = shadow_ctx.fsr0h;
                8'hea:            rdata_d = shadow_ctx.fsr1l;
                8'heb:            rdata_d = shadow_ctx.fsr1h;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctl_q         <= RST_IRQ_CONTROL;
            opt_q         <= RST_OPTION;
            pen_a_q       <= RST_PERIPH;
            pen_b_q       <= RST_PERIPH;
            preq_a_q      <= RST_PERIPH;
            preq_b_q      <= RST_PERIPH;
            q_q           <= 2'h0;
            seq_q         <= SEQ_RUN;
            pin_flag_q1_q <= 1'b0;
            pend_q        <= 1'b0;
            rdata_q       <= 8'h00;
        end
        else
        begin
            ctl_q         <= ctl_d;
            opt_q         <= opt_d;
            pen_a_q       <= pen_a_d;
            pen_b_q       <= pen_b_d;
            preq_a_q      <= preq_a_d;
            preq_b_q      <= preq_b_d;
            q_q           <= q_d;
            seq_q         <= seq_d;
            pin_flag_q1_q <= pin_flag_q1_d;
            pend_q        <= pend_d;
            rdata_q       <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata    = rdata_q;
    assign irq_request  = pend_q & ctl_q[BIT_GLOBAL_EN];
    assign vector_addr  = IRQ_VECTOR;
    assign restore_ctx  = instr_return_from_irq_instr;
    assign restore_data = shadow_ctx;
    assign q_phase      = q_q;

endmodule

// ### testbench/cic_core_irq_properties.sv
// Purpose: Port assertions of the core interrupt control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every instance of the block
`timescale 1ns/10ps
module cic_core_irq_properties
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Observed ports
    input wire logic        instr_return_from_irq_instr,
    input wire logic        core_sleeping,
    input wire logic        irq_request,
    input wire logic        wake_up,
    input wire logic        flush_prefetch,
    input wire logic        push_pc,
    input wire logic        load_vector,
    input wire logic [14:0] vector_addr,
    input wire logic        restore_ctx,
    input wire logic [1:0]  q_phase
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_quiet_after_reset;
        $fell(srst) |-> !irq_request && !flush_prefetch;
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("Request just after reset");
    property p_flush_needs_request;
        flush_prefetch |-> irq_request;
    endproperty
    a_flush_needs_request: assert property (p_flush_needs_request) else $error("Entry without request");
    property p_entry_order;
        flush_prefetch |-> ##4 push_pc ##4 load_vector;
    endproperty
    a_entry_order: assert property (p_entry_order) else $error("Entry sequence out of order");
    property p_vector_fixed;
        load_vector |-> vector_addr == IRQ_VECTOR;
    endproperty
    a_vector_fixed: assert property (p_vector_fixed) else $error("Wrong vector");
    property p_global_cleared;
        flush_prefetch |=> !irq_request [*4];
    endproperty
    a_global_cleared: assert property (p_global_cleared) else $error("Request kept after entry");
    property p_restore_on_return;
        instr_return_from_irq_instr |-> restore_ctx;
    endproperty
    a_restore_on_return: assert property (p_restore_on_return) else $error("No restore on return");
    property p_take_on_q4;
        flush_prefetch |-> q_phase == Q_PHASES;
    endproperty
    a_take_on_q4: assert property (p_take_on_q4) else $error("Entry off the last phase");
    property p_asleep_no_entry;
        core_sleeping |-> !flush_prefetch;
    endproperty
    a_asleep_no_entry: assert property (p_asleep_no_entry) else $error("Entry while asleep");
    property p_wake_needs_sleep;
        wake_up |-> core_sleeping;
    endproperty
    a_wake_needs_sleep: assert property (p_wake_needs_sleep) else $error("Wake while awake");
endmodule

bind cic_core_irq cic_core_irq_properties u_props (.clock(clock), .srst(srst), .instr_return_from_irq_instr(instr_return_from_irq_instr),
    .core_sleeping(core_sleeping), .irq_request(irq_request), .wake_up(wake_up), .flush_prefetch(flush_prefetch),
    .push_pc(push_pc), .load_vector(load_vector), .vector_addr(vector_addr), .restore_ctx(restore_ctx),
    .q_phase(q_phase));

// ### testbench/cic_core_model.sv
// Purpose: Behavioural core sequencer facing the interrupt control block
// Assumes: Bench commands sleep and return
// Notes:   Sleep from sleep_go ends on the block's wake request; sleep_hold keeps the core asleep regardless
`timescale 1ns/10ps
module cic_core_model
    import cic_pkg::*;
(
    // Clock and reset
    input  wire logic     clock,
    input  wire logic     srst,
    // Bench commands
    input  wire logic     sleep_hold,
    input  wire logic     sleep_go,
    input  wire logic     ret_cmd,
    input  wire cic_ctx_t ctx_in,
    // Block side
    input  wire logic     wake_up,
    input  wire logic     load_vector,
    output logic          core_sleeping,
    output logic          instr_return_from_irq_instr,
    output cic_ctx_t      live_ctx,
    output logic [7:0]    entry_count
);
    logic       sleep_q, sleep_d;
    logic [7:0] count_q, count_d;

    always_comb
    begin
        sleep_d = sleep_go | (sleep_q & ~wake_up);
        count_d = count_q + {7'h00, load_vector};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sleep_q <= 1'b0;
            count_q <= 8'h00;
        end
        else
        begin
            sleep_q <= sleep_d;
            count_q <= count_d;
        end
    end

    assign core_sleeping = sleep_hold | sleep_q;
    assign instr_return_from_irq_instr  = ret_cmd;
    assign live_ctx      = ctx_in;
    assign entry_count   = count_q;
endmodule

// ### testbench/tb_cic_core_irq.sv
// Purpose: Self-checking bench of the core interrupt control block
// Assumes: Timer event is the synchronous source
// Notes:   Seeded random enables and events, corner cases by hand
`timescale 1ns/10ps
module tb_cic_core_irq
    import cic_pkg::*;
;
    logic        clock, srst, reg_wr, reg_rd, ext_pin, tmr_event, ioc_pending, sleep_hold, sleep_go, ret_cmd, t, io;
    logic        irq_request, wake_up, flush_prefetch, push_pc, load_vector, restore_ctx, core_sleeping, instr_return_from_irq_instr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, periph_event_a, periph_event_b, entry_count, rd_v, c, ea, eb, pa, pb;
    logic [14:0] vector_addr;
    logic [1:0]  q_phase;
    cic_ctx_t    ctx_in, live_ctx, restore_data, exp_ctx;
    int          bad_count = 0;
    int          n_tests = 0;
    int          lat;
    logic [7:0]  addrs [7] = '{OFF_IRQ_CONTROL, OFF_OPTION, OFF_PERIPH_EN_A, OFF_PERIPH_EN_B, OFF_PERIPH_REQ_A,
                               OFF_PERIPH_REQ_B, 8'h40};
    logic [7:0]  rstv [7]  = '{RST_IRQ_CONTROL, RST_OPTION, RST_PERIPH, RST_PERIPH, RST_PERIPH, RST_PERIPH, 8'h00};

    cic_core_irq DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .tmr_event(tmr_event), .ioc_pending(ioc_pending),
        .periph_event_a(periph_event_a), .periph_event_b(periph_event_b), .instr_return_from_irq_instr(instr_return_from_irq_instr),
        .core_sleeping(core_sleeping), .live_ctx(live_ctx), .irq_request(irq_request), .wake_up(wake_up),
        .flush_prefetch(flush_prefetch), .push_pc(push_pc), .load_vector(load_vector), .vector_addr(vector_addr),
        .restore_ctx(restore_ctx), .restore_data(restore_data), .q_phase(q_phase));
    cic_core_model u_core (.clock(clock), .srst(srst), .sleep_hold(sleep_hold), .sleep_go(sleep_go),
        .ret_cmd(ret_cmd), .ctx_in(ctx_in), .wake_up(wake_up), .load_vector(load_vector),
        .core_sleeping(core_sleeping), .instr_return_from_irq_instr(instr_return_from_irq_instr), .live_ctx(live_ctx), .entry_count(entry_count));

    function automatic logic qual(logic [7:0] cv, logic [7:0] ra, logic [7:0] ka, logic [7:0] rb, logic [7:0] kb);
        return (cv[BIT_TMR_EN] & cv[BIT_TMR_FLAG]) | (cv[BIT_PIN_EN] & cv[BIT_PIN_FLAG])
            | (cv[BIT_IOC_EN] & cv[BIT_IOC_FLAG])
            | (cv[BIT_GROUP_EN] & (|(ra & ka & MASK_PERIPH_A) | |(rb & kb & MASK_PERIPH_B)));
    endfunction

    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        check($sformatf("reg %h", a), {56'h0, e}, {56'h0, rd_v});
        @(posedge clock);
    endtask

    task automatic fire(input logic [7:0] a, input logic [7:0] b, input logic tv);
        periph_event_a <= a;
        periph_event_b <= b;
        tmr_event      <= tv;
        @(posedge clock);
        periph_event_a <= 8'h00;
        periph_event_b <= 8'h00;
        tmr_event      <= 1'b0;
        @(posedge clock);
    endtask

    task automatic trigger(input logic tv, input logic pv);
        tmr_event <= tv;
        ext_pin   <= pv;
        @(posedge clock);
        tmr_event <= 1'b0;
        #1 lat = 0;
        while (load_vector !== 1'b1 && lat < 40)
        begin
            @(posedge clock);
            #1 lat++;
        end
        exp_ctx        = ctx_in;
        exp_ctx.status = ctx_in.status & MASK_STATUS_SAVE;
    endtask

    task automatic serve(input logic [7:0] cv);
        wr(OFF_IRQ_CONTROL, cv);
        ret_cmd <= 1'b1;
        @(posedge clock);
        ret_cmd <= 1'b0;
        #1 check("restore_data", exp_ctx, restore_data);
        @(posedge clock);
        rchk(OFF_IRQ_CONTROL, cv | 8'h80);
        wr(OFF_IRQ_CONTROL, 8'h00);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #200us;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        {srst, reg_wr, reg_rd, ext_pin, tmr_event, ioc_pending, sleep_hold, sleep_go, ret_cmd} = 9'h100;
        {reg_addr, reg_wdata, periph_event_a, periph_event_b} = 32'h0;
        ctx_in  = 64'h0;
        exp_ctx = 64'h0;
        void'($urandom(32'h1f11a73c));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        foreach (addrs[i])
            rchk(addrs[i], rstv[i]);
        wr(OFF_PERIPH_EN_A, 8'hff);
        wr(OFF_PERIPH_EN_B, 8'hff);
        rchk(OFF_PERIPH_EN_A, MASK_PERIPH_A);
        rchk(OFF_PERIPH_EN_B, MASK_PERIPH_B);
        $display("test reset_and_masks done");
        sleep_hold <= 1'b1;
        repeat (24)
        begin
            c  = 8'($urandom) & 8'hf8;
            ea = 8'($urandom);
            eb = 8'($urandom);
            pa = 8'($urandom);
            pb = 8'($urandom);
            t  = 1'($urandom);
            io = 1'($urandom);
            ioc_pending <= io;
            wr(OFF_IRQ_CONTROL, c);
            wr(OFF_PERIPH_EN_A, ea);
            wr(OFF_PERIPH_EN_B, eb);
            fire(pa, pb, t);
            repeat (6) @(posedge clock);
            #1 c = c | {5'h00, t, 1'b0, io};
            check("wake_up", qual(c, pa, ea, pb, eb), wake_up);
            check("irq_request", c[BIT_GLOBAL_EN] & qual(c, pa, ea, pb, eb), irq_request);
            rchk(OFF_IRQ_CONTROL, c);
            rchk(OFF_PERIPH_REQ_A, pa & MASK_PERIPH_A);
            rchk(OFF_PERIPH_REQ_B, pb & MASK_PERIPH_B);
            wr(OFF_PERIPH_REQ_A, 8'h00);
            wr(OFF_PERIPH_REQ_B, 8'h00);
        end
        wr(OFF_IRQ_CONTROL, 8'h00);
        ioc_pending <= 1'b0;
        sleep_hold  <= 1'b0;
        $display("test random_qualify done");
        ctx_in <= {$urandom, $urandom};
        wr(OFF_IRQ_CONTROL, 8'ha0);
        trigger(1'b1, 1'b0);
        check("sync latency", 1, lat >= 8 && lat <= 16);
        rchk(OFF_IRQ_CONTROL, 8'h24);
        for (int i = 0; i < SHADOW_WORDS; i++)
            rchk(OFF_SHADOW_BASE + 8'(i), exp_ctx[63-8*i -: 8]);
        for (int i = 0; i < SHADOW_WORDS; i++)
        begin
            pa = 8'($urandom);
            wr(OFF_SHADOW_BASE + 8'(i), pa);
            exp_ctx[63-8*i -: 8] = pa;
        end
        exp_ctx.status &= MASK_STATUS_SAVE;
        for (int i = 0; i < SHADOW_WORDS; i++)
            rchk(OFF_SHADOW_BASE + 8'(i), exp_ctx[63-8*i -: 8]);
        serve(8'h20);
        $display("test entry_and_return done");
        for (int s = 1; s >= 0; s--)
        begin
            wr(OFF_OPTION, {1'b1, s[0], 6'h3f});
            ext_pin <= s[0];
            repeat (8) @(posedge clock);
            wr(OFF_IRQ_CONTROL, 8'h10);
            ext_pin <= ~s[0];
            repeat (12) @(posedge clock);
            rchk(OFF_IRQ_CONTROL, 8'h10);
            wr(OFF_IRQ_CONTROL, 8'h90);
            trigger(1'b0, s[0]);
            check("pin latency", 1, lat >= 8 && lat <= 20);
            rchk(OFF_IRQ_CONTROL, 8'h12);
            serve(8'h10);
        end
        $display("test pin_edges done");
        wr(OFF_IRQ_CONTROL, 8'h20);
        fire(8'h00, 8'h00, 1'b1);
        repeat (12) @(posedge clock);
        c = entry_count;
        rchk(OFF_IRQ_CONTROL, 8'h24);
        check("held entries", {56'h0, c}, {56'h0, entry_count});
        wr(OFF_IRQ_CONTROL, 8'ha4);
        trigger(1'b0, ext_pin);
        check("late entry", 1, lat < 40);
        serve(8'h20);
        $display("test pending_taken done");
        wr(OFF_IRQ_CONTROL, 8'ha0);
        sleep_go <= 1'b1;
        @(posedge clock);
        sleep_go <= 1'b0;
        trigger(1'b1, ext_pin);
        check("wake entry", 1, lat < 40 && core_sleeping === 1'b0);
        serve(8'h20);
        $display("test wake_entry done");
        tally_and_finish();
    end
endmodule
